/* design/rsmd_multidrop.sv */
/*
 * Multidrop extension of a UART: address filtering of 9-bit received
 * characters into a receive queue, baud oversample generator and automatic
 * transceiver direction control with a turn-off delay.
 * Assumes the UART receiver hands over whole characters with valid/ready,
 * the transmitter pulses tx_done when the final stop bit has left, and the
 * divisor latch value arrives as a port.
 */
// Contract
// - 8-bit address compare value, resets zero.
// - Wait 0..255 baud periods before release.
// - Delay timed by an 8-bit counter.
// - Multidrop flags address characters as parity error.
// - Receiver disabled: keep addresses, drop data.
// - Receiver enabled: keep all, flag addresses.
// - Both bits set: compare addresses automatically.
// - Auto, disabled: discard data and mismatches.
// - Match: store, enable receiver, signal ready.
// - Auto, enabled: mismatch disables, not stored.
// - Control bit four enables direction control.
// - Bit three picks request or terminal pin.
// - Low on transmit write, high when done.
// - Direction control overrides all except loopback.
// - Bit five inverts direction output polarity.
// - Divisor produces sixteen-times oversample enable.
`timescale 1ns/1ps

module rsmd_multidrop
	import rsmd_pkg::*;
#(
	parameter int QUEUE_DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_char_valid,
	input wire rsmd_char_t rx_char,
	output logic rx_char_ready,
	output logic rx_data_ready,
	output logic parity_error,
	input wire logic tx_done,
	input wire logic [15:0] divisor_value,
	output logic oversample_enable,
	input wire logic loopback_mode,
	input wire logic rts_manual_n,
	input wire logic dtr_manual_n,
	output logic rts_n,
	output logic dtr_n
);

	// Bus, register and filter state.
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [RSMD_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [7:0] match_ff, nxt_match;
	logic [7:0] delay_ff, nxt_delay;
	logic rdr_ff, nxt_rdr;
	logic perr_ff, nxt_perr;
	logic setup_rd, setup_wr, mapped, thr_write;
	logic accept, store, is_addr, is_match;
	logic hw_set_rxdis, hw_clr_rxdis;
	logic q_in_ready, q_out_valid, q_pop;
	rsmd_char_t q_out;

	// Baud and direction state.
	logic [15:0] div_cnt_ff, nxt_div_cnt;
	logic os_ff, nxt_os;
	rsmd_dir_state_t dir_ff, nxt_dir;
	logic [3:0] sub_ff, nxt_sub;
	logic [7:0] hold_cnt_ff, nxt_hold_cnt;
	logic rts_n_ff, nxt_rts_n;
	logic dtr_n_ff, nxt_dtr_n;
	logic dir_level;

	// Address decode shared by reads and writes.
	function automatic logic is_mapped(input logic [31:0] a);
		return (a == RSMD_DATA_ADDR) || (a == RSMD_CTRL_ADDR) ||
			(a == RSMD_MATCH_ADDR) || (a == RSMD_DELAY_ADDR);
	endfunction

	assign setup_rd = psel && !penable && !pwrite;
	assign setup_wr = psel && !penable && pwrite;
	assign mapped = is_mapped(paddr);
	assign thr_write = setup_wr && (paddr == RSMD_DATA_ADDR);
	assign q_pop = setup_rd && (paddr == RSMD_DATA_ADDR) && q_out_valid;

	// Receive classification; the source stalls while the queue is full.
	assign accept = rx_char_valid && q_in_ready;
	assign is_addr = rx_char.addr_flag;
	assign is_match = is_addr && (rx_char.data == match_ff);

	// Decide whether an accepted character enters the queue, and what the
	// hardware does to the receive-disable bit.
	always_comb begin
		store = 1'b1;
		hw_set_rxdis = 1'b0;
		hw_clr_rxdis = 1'b0;
		if (ctrl_ff[RSMD_MDROP_BIT] && ctrl_ff[RSMD_AUTO_BIT]) begin
			if (ctrl_ff[RSMD_RXDIS_BIT]) begin
				store = is_match;
				hw_clr_rxdis = accept && is_match;
			end else if (is_addr && !is_match) begin
				store = 1'b0;
				hw_set_rxdis = accept;
			end
		end else if (ctrl_ff[RSMD_MDROP_BIT]) begin
			store = ctrl_ff[RSMD_RXDIS_BIT] ? is_addr : 1'b1;
		end
	end

	// Register writes, hardware updates of the control bits and the
	// one-cycle event pulses. A hardware change of receive-disable wins
	// over a software write in the same cycle.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_match = match_ff;
		nxt_delay = delay_ff;
		if (setup_wr && paddr == RSMD_CTRL_ADDR) begin
			nxt_ctrl = pwdata[RSMD_CTRL_W-1:0];
		end
		if (setup_wr && paddr == RSMD_MATCH_ADDR) begin
			nxt_match = pwdata[7:0];
		end
		if (setup_wr && paddr == RSMD_DELAY_ADDR) begin
			nxt_delay = pwdata[7:0];
		end
		if (hw_clr_rxdis) begin
			nxt_ctrl[RSMD_RXDIS_BIT] = 1'b0;
		end
		if (hw_set_rxdis) begin
			nxt_ctrl[RSMD_RXDIS_BIT] = 1'b1;
		end
		nxt_rdr = accept && store;
		nxt_perr = accept && is_addr && ctrl_ff[RSMD_MDROP_BIT];
	end

	// Bus answer: data is latched in the setup phase and shown with ready
	// in the access phase; an unmapped address answers with an error.
	always_comb begin
		nxt_prdata = '0;
		nxt_pready = psel && !penable;
		nxt_pslverr = psel && !penable && !mapped;
		if (setup_rd) begin
			unique case (paddr)
				RSMD_DATA_ADDR: nxt_prdata = q_out_valid ?
					32'(q_out) : 32'h0000_0000;
				RSMD_CTRL_ADDR: nxt_prdata = 32'(ctrl_ff);
				RSMD_MATCH_ADDR: nxt_prdata = 32'(match_ff);
				RSMD_DELAY_ADDR: nxt_prdata = 32'(delay_ff);
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Bus and register flip-flops.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			ctrl_ff <= RSMD_CTRL_RST;
			match_ff <= RSMD_MATCH_RST;
			delay_ff <= RSMD_DELAY_RST;
			rdr_ff <= 1'b0;
			perr_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			ctrl_ff <= nxt_ctrl;
			match_ff <= nxt_match;
			delay_ff <= nxt_delay;
			rdr_ff <= nxt_rdr;
			perr_ff <= nxt_perr;
		end
	end

	// Receive queue between the filter and the register reads.
	rsmd_fifo #(
		.WIDTH($bits(rsmd_char_t)),
		.DEPTH(QUEUE_DEPTH)
	) u_receive_queue (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(rx_char_valid && store),
		.in_ready(q_in_ready),
		.in_data(rx_char),
		.out_valid(q_out_valid),
		.out_ready(q_pop),
		.out_data(q_out)
	);

	// Oversample generator: one tick every divisor clocks, zero taken as one.
	always_comb begin
		nxt_div_cnt = 16'(div_cnt_ff + 1'b1);
		nxt_os = 1'b0;
		if (divisor_value <= 16'h0001 ||
			div_cnt_ff >= 16'(divisor_value - 1'b1)) begin
			nxt_div_cnt = 16'h0000;
			nxt_os = 1'b1;
		end
	end

	// Direction sequencer: active from a transmit write until the final
	// stop bit, then held for the programmed number of baud periods.
	always_comb begin
		nxt_dir = dir_ff;
		nxt_sub = sub_ff;
		nxt_hold_cnt = hold_cnt_ff;
		unique case (dir_ff)
			RSMD_DIR_IDLE: begin
				if (thr_write) begin
					nxt_dir = RSMD_DIR_ACTIVE;
				end
			end
			RSMD_DIR_ACTIVE: begin
				if (tx_done && !thr_write) begin
					nxt_sub = 4'h0;
					nxt_hold_cnt = 8'h00;
					nxt_dir = (delay_ff == 8'h00) ?
						RSMD_DIR_IDLE : RSMD_DIR_HOLD;
				end
			end
			RSMD_DIR_HOLD: begin
				if (thr_write) begin
					nxt_dir = RSMD_DIR_ACTIVE;
				end else if (os_ff) begin
					nxt_sub = 4'(sub_ff + 1'b1);
					if (sub_ff == RSMD_LAST_TICK) begin
						nxt_hold_cnt = 8'(hold_cnt_ff + 1'b1);
						if (8'(hold_cnt_ff + 1'b1) >= delay_ff) begin
							nxt_dir = RSMD_DIR_IDLE;
						end
					end
				end
			end
		endcase
	end

	// Pin levels: loopback first, then automatic direction on the selected
	// pin, otherwise the ordinary modem outputs.
	always_comb begin
		dir_level = (dir_ff != RSMD_DIR_IDLE) ^ !ctrl_ff[RSMD_OINV_BIT];
		nxt_rts_n = rts_manual_n;
		nxt_dtr_n = dtr_manual_n;
		if (loopback_mode) begin
			nxt_rts_n = 1'b1;
			nxt_dtr_n = 1'b1;
		end else if (ctrl_ff[RSMD_DCTRL_BIT]) begin
			if (ctrl_ff[RSMD_SEL_BIT]) begin
				nxt_dtr_n = dir_level;
			end else begin
				nxt_rts_n = dir_level;
			end
		end
	end

	// Baud and direction flip-flops.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_cnt_ff <= 16'h0000;
			os_ff <= 1'b0;
			dir_ff <= RSMD_DIR_IDLE;
			sub_ff <= 4'h0;
			hold_cnt_ff <= 8'h00;
			rts_n_ff <= 1'b1;
			dtr_n_ff <= 1'b1;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			os_ff <= nxt_os;
			dir_ff <= nxt_dir;
			sub_ff <= nxt_sub;
			hold_cnt_ff <= nxt_hold_cnt;
			rts_n_ff <= nxt_rts_n;
			dtr_n_ff <= nxt_dtr_n;
		end
	end

	// Outputs, each straight from a flip-flop.
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign rx_char_ready = q_in_ready;
	assign rx_data_ready = rdr_ff;
	assign parity_error = perr_ff;
	assign oversample_enable = os_ff;
	assign rts_n = rts_n_ff;
	assign dtr_n = dtr_n_ff;

	// Checks on filtering, direction control and the oversample tick.
	match_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		setup_wr && paddr == RSMD_MATCH_ADDR |=>
		match_ff == $past(pwdata[7:0]))
		else $error("address compare value not written");

	auto_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && ctrl_ff[0] && ctrl_ff[2] && ctrl_ff[1] && !is_match
		|=> !rdr_ff && ctrl_ff[1])
		else $error("character kept while receiver disabled");

	match_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && ctrl_ff[0] && ctrl_ff[2] && ctrl_ff[1] && is_match
		|=> rdr_ff && !ctrl_ff[1])
		else $error("matching address did not enable receiver");

	mismatch_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && ctrl_ff[0] && ctrl_ff[2] && !ctrl_ff[1] && is_addr &&
		!is_match |=> ctrl_ff[1] && !rdr_ff)
		else $error("mismatching address not rejected");

	mdrop_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && ctrl_ff[0] && !ctrl_ff[2] && ctrl_ff[1]
		|=> rdr_ff == $past(is_addr))
		else $error("normal mode filtering wrong");

	addr_perr_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && ctrl_ff[0] && is_addr |=> parity_error)
		else $error("address character not flagged");

	dir_assert_a: assert property (@(posedge clk) disable iff (sys_rst)
		thr_write && ctrl_ff == 6'h10 && !loopback_mode &&
		$stable(ctrl_ff) ##1 !loopback_mode && ctrl_ff == 6'h10
		|=> !rts_n)
		else $error("direction pin not asserted on transmit write");

	dir_invert_a: assert property (@(posedge clk) disable iff (sys_rst)
		dir_ff != RSMD_DIR_IDLE && !loopback_mode && ctrl_ff == 6'h30
		|=> rts_n)
		else $error("inverted direction level wrong");

	loop_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
		loopback_mode |=> rts_n && dtr_n)
		else $error("loopback did not take the pins");

	zero_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
		dir_ff == RSMD_DIR_ACTIVE && tx_done && !thr_write &&
		delay_ff == 8'h00 |=> dir_ff == RSMD_DIR_IDLE)
		else $error("zero delay did not release at once");

	hold_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
		dir_ff == RSMD_DIR_HOLD |-> hold_cnt_ff < delay_ff)
		else $error("turn-off counter passed programmed delay");

	tick_width_a: assert property (@(posedge clk) disable iff (sys_rst)
		oversample_enable && divisor_value > 16'h0001 &&
		$stable(divisor_value) |=> !oversample_enable)
		else $error("oversample tick wider than one clock");

	hold_cover: cover property (@(posedge clk) disable iff (sys_rst)
		dir_ff == RSMD_DIR_HOLD ##1 dir_ff == RSMD_DIR_IDLE);
	match_cover: cover property (@(posedge clk) disable iff (sys_rst)
		hw_clr_rxdis);
	reject_cover: cover property (@(posedge clk) disable iff (sys_rst)
		hw_set_rxdis);

endmodule // rsmd_multidrop

/* design/rsmd_pkg.sv */
/*
 * Shared constants and types for the multidrop receive filter and the
 * transceiver direction control.
 * Assumes a 32-bit peripheral bus with word-aligned registers.
 */
package rsmd_pkg;

	// Register byte addresses on the peripheral bus.
	localparam logic [31:0] RSMD_DATA_ADDR = 32'h4000_8000;
	localparam logic [31:0] RSMD_CTRL_ADDR = 32'h4000_804C;
	localparam logic [31:0] RSMD_MATCH_ADDR = 32'h4000_8050;
	localparam logic [31:0] RSMD_DELAY_ADDR = 32'h4000_8054;

	// Field positions in the multidrop control register.
	localparam int RSMD_MDROP_BIT = 0;
	localparam int RSMD_RXDIS_BIT = 1;
	localparam int RSMD_AUTO_BIT = 2;
	localparam int RSMD_SEL_BIT = 3;
	localparam int RSMD_DCTRL_BIT = 4;
	localparam int RSMD_OINV_BIT = 5;
	localparam int RSMD_CTRL_W = 6;

	// Reset values.
	localparam logic [5:0] RSMD_CTRL_RST = 6'h00;
	localparam logic [7:0] RSMD_MATCH_RST = 8'h00;
	localparam logic [7:0] RSMD_DELAY_RST = 8'h00;

	// Oversample ticks in one baud period.
	localparam int RSMD_OVERSAMPLE = 16;
	localparam logic [3:0] RSMD_LAST_TICK = 4'(RSMD_OVERSAMPLE - 1);

	// One received character: ninth bit and the data byte.
	typedef struct packed {
		logic addr_flag;
		logic [7:0] data;
	} rsmd_char_t;

	// Direction control states.
	typedef enum logic [1:0] {
		RSMD_DIR_IDLE,
		RSMD_DIR_ACTIVE,
		RSMD_DIR_HOLD
	} rsmd_dir_state_t;

endpackage

/* design/rsmd_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module rsmd_fifo
	import rsmd_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] count_ff, nxt_count;
	logic room_ff, nxt_room;
	logic push, pop;

	// Push and pop are qualified by the handshakes on each side.
	assign push = in_valid && room_ff;
	assign pop = out_ready && (count_ff != '0);
	assign in_ready = room_ff; // Straight from a flop, no inverter.
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];

	// Next pointers, fill level and full flag.
	always_comb begin
		nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
		nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = (AW+1)'(count_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_count = (AW+1)'(count_ff - 1'b1);
		end
		nxt_room = (nxt_count != (AW+1)'(DEPTH));
	end

	// Pointer and level registers.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			room_ff <= 1'b1;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
			room_ff <= nxt_room;
		end
	end

	// Storage has no reset; only pushed words are ever read.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

endmodule // rsmd_fifo

/* verification/rsmd_partner.sv */
/*
 * Far side model: the receive path that carries characters sent by the
 * remote bus master towards the multidrop filter.
 * Assumes one clock and that callers enter just after a rising edge.
 */
`timescale 1ns/1ps

module rsmd_partner
	import rsmd_pkg::*;
(
	input wire logic clk,
	input wire logic rx_char_ready,
	output logic rx_char_valid,
	output rsmd_char_t rx_char
);

	// Offers one character after some idle cycles and holds it until taken, for at most 64 edges.
	task automatic send(input logic is_addr, input logic [7:0] value,
		input int idle, output logic taken);
		logic ok;
		taken = 1'b0;
		repeat (idle) begin
			@(posedge clk);
			#1;
		end
		rx_char.addr_flag = is_addr;
		rx_char.data = value;
		rx_char_valid = 1'b1;
		// Ready is read one step after an edge, so it is the settled value
		// that the next edge will see.
		for (int i = 0; i < 64 && !taken; i++) begin
			ok = rx_char_ready;
			@(posedge clk);
			#1;
			taken = ok;
		end
		rx_char_valid = 1'b0;
		// A released line shows no stale value.
		rx_char = ~rx_char;
	endtask

	// Idle line at time zero.
	initial begin
		rx_char_valid = 1'b0;
		rx_char = '0;
	end

endmodule // rsmd_partner

/* verification/rsmd_multidrop_test.sv */
/*
 * Self-checking bench for the multidrop filter and direction control.
 * Assumes the partner model feeds received characters and that the bench
 * acts as bus master and transmitter.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	miscompares++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module rsmd_multidrop_test
	import rsmd_pkg::*;
;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic rx_char_valid, rx_char_ready, rx_data_ready, parity_error;
	rsmd_char_t rx_char;
	logic tx_done, oversample_enable, loopback_mode;
	logic rts_manual_n, dtr_manual_n, rts_n, dtr_n;
	logic [15:0] divisor_value;
	int miscompares = 0;
	int compares = 0;
	int n_rdy = 0;
	int n_perr = 0;

	rsmd_multidrop #(.QUEUE_DEPTH(16)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .rx_char_ready(rx_char_ready),
		.rx_data_ready(rx_data_ready), .parity_error(parity_error),
		.tx_done(tx_done), .divisor_value(divisor_value),
		.oversample_enable(oversample_enable),
		.loopback_mode(loopback_mode), .rts_manual_n(rts_manual_n),
		.dtr_manual_n(dtr_manual_n), .rts_n(rts_n), .dtr_n(dtr_n));

	rsmd_partner i_partner (.clk(clk), .rx_char_ready(rx_char_ready),
		.rx_char_valid(rx_char_valid), .rx_char(rx_char));

	// Clock of 100 MHz.
	always #5 clk = ~clk;

	// Counts the receive pulses seen at each edge.
	always @(posedge clk) begin
		if (rx_data_ready === 1'b1) n_rdy++;
		if (parity_error === 1'b1) n_perr++;
	end

	task automatic give_verdict();
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One bus transfer: setup, then access until ready, then release.
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel = 1'b1;
		penable = 1'b0;
		pwrite = wr;
		paddr = a;
		pwdata = wd;
		@(posedge clk);
		#1;
		penable = 1'b1;
		for (int i = 0; i < 8 && pready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (pready !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		@(posedge clk);
		#1;
		psel = 1'b0;
		penable = 1'b0;
		// An idle edge keeps the strobes from changing twice in one step.
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		bus(1'b1, a, d, rd, e);
	endtask

	task automatic rdchk(input string nm, input logic [31:0] a,
		input logic [31:0] ex);
		logic [31:0] rd;
		logic e;
		bus(1'b0, a, 32'h0, rd, e);
		`CHK(nm, ex, rd)
	endtask

	// Sends one character and judges the pulses that follow it.
	task automatic rx(input logic f, input logic [7:0] b, input int sto,
		input int perr);
		int r0;
		int p0;
		logic t;
		r0 = n_rdy;
		p0 = n_perr;
		i_partner.send(f, b, 0, t);
		repeat (2) @(posedge clk);
		#1;
		`CHK("taken", 1'b1, t)
		`CHK("stored", sto, n_rdy - r0)
		`CHK("address flag", perr, n_perr - p0)
	endtask

	function automatic logic pin(input logic s);
		return s ? dtr_n : rts_n;
	endfunction

	// Reset values, read-back, upper bits and an unmapped address.
	task automatic t_regs();
		logic [31:0] rd;
		logic e;
		rdchk("ctrl", RSMD_CTRL_ADDR, 32'h0);
		rdchk("match", RSMD_MATCH_ADDR, 32'h0);
		rdchk("delay", RSMD_DELAY_ADDR, 32'h0);
		wr(RSMD_MATCH_ADDR, 32'hFFFF_FFA5);
		rdchk("match", RSMD_MATCH_ADDR, 32'h0000_00A5);
		wr(RSMD_DELAY_ADDR, 32'h0000_00FF);
		rdchk("delay", RSMD_DELAY_ADDR, 32'h0000_00FF);
		bus(1'b0, 32'h4000_8058, 32'h0, rd, e);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, rd)
	endtask

	// Normal multidrop with the receiver off and then on.
	task automatic t_normal();
		wr(RSMD_CTRL_ADDR, 32'h0000_0003);
		rx(1'b0, 8'h11, 0, 0);
		rx(1'b1, 8'h22, 1, 1);
		rdchk("queue", RSMD_DATA_ADDR, 32'h0000_0122);
		wr(RSMD_CTRL_ADDR, 32'h0000_0001);
		rx(1'b0, 8'h33, 1, 0);
		rx(1'b1, 8'h44, 1, 1);
		rdchk("queue", RSMD_DATA_ADDR, 32'h0000_0033);
		rdchk("queue", RSMD_DATA_ADDR, 32'h0000_0144);
		rdchk("empty", RSMD_DATA_ADDR, 32'h0);
	endtask

	// Automatic detection: drop, match, accept, then a foreign address.
	task automatic t_auto();
		wr(RSMD_MATCH_ADDR, 32'h0000_0005);
		wr(RSMD_CTRL_ADDR, 32'h0000_0007);
		rx(1'b0, 8'h10, 0, 0);
		rx(1'b1, 8'h06, 0, 1);
		rx(1'b1, 8'h05, 1, 1);
		rdchk("ctrl", RSMD_CTRL_ADDR, 32'h0000_0005);
		rx(1'b0, 8'h20, 1, 0);
		rx(1'b1, 8'h09, 0, 1);
		rdchk("ctrl", RSMD_CTRL_ADDR, 32'h0000_0007);
		rdchk("queue", RSMD_DATA_ADDR, 32'h0000_0105);
		rdchk("queue", RSMD_DATA_ADDR, 32'h0000_0020);
		rdchk("empty", RSMD_DATA_ADDR, 32'h0);
	endtask

	// Fills the queue until it refuses, then drains it in order.
	task automatic t_fifo();
		wr(RSMD_CTRL_ADDR, 32'h0);
		for (int i = 0; i < 16; i++) rx(1'b0, 8'(i + 8'h60), 1, 0);
		`CHK("full refuses", 1'b0, rx_char_ready)
		for (int i = 0; i < 16; i++) begin
			rdchk("drain", RSMD_DATA_ADDR, 32'(i + 8'h60));
		end
		rdchk("empty", RSMD_DATA_ADDR, 32'h0);
	endtask

	// Interval between oversample pulses equals the divisor.
	task automatic t_baud();
		int n;
		divisor_value = 16'h0004;
		for (n = 0; n < 20 && oversample_enable !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (oversample_enable !== 1'b1 && n < 20);
		`CHK("tick interval", 4, n)
		divisor_value = 16'h0001;
	endtask

	// Direction pin over one transmission with a given setup.
	task automatic t_dir(input logic [5:0] c, input logic [7:0] d,
		input logic lb);
		logic act;
		logic s;
		act = c[RSMD_OINV_BIT];
		s = c[RSMD_SEL_BIT];
		loopback_mode = lb;
		wr(RSMD_DELAY_ADDR, {24'h0, d});
		wr(RSMD_CTRL_ADDR, {26'h0, c});
		`CHK("idle pin", lb | ~act, pin(s))
		wr(RSMD_DATA_ADDR, 32'h0000_0055);
		@(posedge clk);
		#1;
		`CHK("busy pin", lb | act, pin(s))
		`CHK("other pin", lb, pin(~s))
		tx_done = 1'b1;
		@(posedge clk);
		#1;
		tx_done = 1'b0;
		repeat (int'(d) * 16) @(posedge clk);
		#1;
		`CHK("held pin", lb | act, pin(s))
		for (int i = 0; i < 4 && pin(s) !== (lb | ~act); i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("released pin", lb | ~act, pin(s))
	endtask

	// Main sequence.
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, tx_done, loopback_mode} = 5'h00;
		{paddr, pwdata} = 64'h0;
		{rts_manual_n, dtr_manual_n} = 2'h0;
		divisor_value = 16'h0001;
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_regs();
		t_normal();
		t_auto();
		t_fifo();
		t_baud();
		t_dir(6'h10, 8'h00, 1'b0);
		t_dir(6'h18, 8'h00, 1'b0);
		t_dir(6'h30, 8'h00, 1'b0);
		t_dir(6'h10, 8'h02, 1'b0);
		t_dir(6'h10, 8'h00, 1'b1);
		give_verdict();
	end

	// Cuts a hang short.
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end

endmodule // rsmd_multidrop_test
